// ==== verilog/link_eq_regs.sv ====
`timescale 1ns/1ps
// Behaviour
// - Restart bit high restarts adaptation, both ports
// - Floor apply ignored unless override enabled
// - Enabled floor apply uses programmed floor level
// - Done flag set once pin decode latched
// - Pin codes: B in 6-4, A in 2-0
// - Output divider override selects software field
// - Output code maps to divide 32 down to 1
// - Input divider override selects software field
// - Input code divides reference by 1,2,4,8
// - Errors counted only while count enabled
// - Enabled count drops lock at threshold, reset 3
// - Counting disabled drops lock on first error
// - Reverse mode miso driver enable per pin mode
// - Polarity picks drive edge (spi_drive_rise)
// - Mode codes 000-011 select GPIO variants
// - Mode codes 100-111 select SPI variants
// - Bypass uses first stage as bits 5-3
// - Bypass uses second stage as bits 2-0
// - Applied floor starts adaptation, resets to 8
module link_eq_regs (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic [7:0]      reg_rdata,
	input  wire logic [2:0] mode_a_level,
	input  wire logic       mode_a_valid,
	input  wire logic [2:0] mode_b_level,
	input  wire logic       mode_b_valid,
	input  wire logic [2:0] auto_out_div_code,
	input  wire logic [1:0] auto_in_div_code,
	input  wire logic [5:0] adapt_eq_level,
	input  wire logic [2:0] link_err,
	input  wire logic       link_relock,
	input  wire logic       spi_ss_n,
	input  wire logic       spi_miso_data,
	output logic [1:0]      eq_restart,
	output logic [3:0]      eq_start_level,
	output logic            eq_manual_en,
	output logic [5:0]      eq_manual_setting,
	output logic [5:0]      mclk_out_div,
	output logic [3:0]      ref_in_div,
	output logic            link_lock,
	output logic            spi_miso_o,
	output logic            spi_miso_oe,
	output logic            spi_drive_rise,
	output logic            ctrl_high_speed,
	output logic [2:0]      ctrl_gpio_lanes,
	output logic            ctrl_spi_fwd,
	output logic            ctrl_spi_rev
);
	import link_eq_pkg::*;

	// ***************************************************************
	// Writable registers
	// ***************************************************************
	logic [7:0] eq_ctrl_one_q, eq_ctrl_one_d;
	logic [7:0] audio_div_q, audio_div_d;
	logic [7:0] link_err_q, link_err_d;
	logic [7:0] back_ch_q, back_ch_d;
	logic [7:0] eq_bypass_q, eq_bypass_d;
	logic [7:0] eq_floor_q, eq_floor_d;
	logic [7:0] mode_status_q, mode_status_d;
	logic [7:0] rdata_q, rdata_d;

	// Only writable bits take the bus value; the rest keep their reset value
	function automatic logic [7:0] masked_write(input logic [7:0] wdata, input logic [7:0] mask,
		input logic [7:0] rstv);
		return (wdata & mask) | (rstv & ~mask);
	endfunction

	// Register writes; the restart bit is a plain level, software clears it
	always_comb begin
		eq_ctrl_one_d = eq_ctrl_one_q;
		audio_div_d = audio_div_q;
		link_err_d = link_err_q;
		back_ch_d = back_ch_q;
		eq_bypass_d = eq_bypass_q;
		eq_floor_d = eq_floor_q;
		if (reg_wr) begin
			unique case (reg_addr)
				ADDR_EQ_CTRL_ONE: begin
					eq_ctrl_one_d = masked_write(reg_wdata, WMASK_EQ_CTRL_ONE, RST_EQ_CTRL_ONE);
				end
				ADDR_AUDIO_DIV: begin
					audio_div_d = masked_write(reg_wdata, WMASK_AUDIO_DIV, RST_AUDIO_DIV);
				end
				ADDR_LINK_ERR: begin
					link_err_d = masked_write(reg_wdata, WMASK_LINK_ERR, RST_LINK_ERR);
				end
				ADDR_BACK_CHANNEL: begin
					back_ch_d = masked_write(reg_wdata, WMASK_BACK_CH, RST_BACK_CHANNEL);
				end
				ADDR_EQ_BYPASS: begin
					eq_bypass_d = masked_write(reg_wdata, WMASK_EQ_BYPASS, RST_EQ_BYPASS);
				end
				ADDR_EQ_FLOOR: begin
					eq_floor_d = masked_write(reg_wdata, WMASK_EQ_FLOOR, RST_EQ_FLOOR);
				end
				default: begin
					// Read-only and unmapped addresses ignore writes
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			eq_ctrl_one_q <= RST_EQ_CTRL_ONE;
			audio_div_q <= RST_AUDIO_DIV;
			link_err_q <= RST_LINK_ERR;
			back_ch_q <= RST_BACK_CHANNEL;
			eq_bypass_q <= RST_EQ_BYPASS;
			eq_floor_q <= RST_EQ_FLOOR;
		end else begin
			eq_ctrl_one_q <= eq_ctrl_one_d;
			audio_div_q <= audio_div_d;
			link_err_q <= link_err_d;
			back_ch_q <= back_ch_d;
			eq_bypass_q <= eq_bypass_d;
			eq_floor_q <= eq_floor_d;
		end
	end

	// ***************************************************************
	// Pin synchronisers
	// ***************************************************************
	logic [8:0] pin_meta_q, pin_sync_q;
	logic [8:0] pin_raw;

	assign pin_raw = {spi_ss_n, mode_b_valid, mode_b_level, mode_a_valid, mode_a_level};

	// Two stages per pin; the first stage feeds only the second
	always_ff @(posedge clk) begin
		if (rst) begin
			pin_meta_q <= 9'h100;
			pin_sync_q <= 9'h100;
		end else begin
			pin_meta_q <= pin_raw;
			pin_sync_q <= pin_meta_q;
		end
	end

	// ***************************************************************
	// Mode pin decode status
	// ***************************************************************
	// Each code is caught once when its valid is seen, then held until reset.
	// The pin decoder must hold the code steady before raising valid, since the
	// three code bits are synchronised separately.
	always_comb begin
		mode_status_d = mode_status_q;
		if (pin_sync_q[3] && !mode_status_q[BIT_PIN_A_DONE]) begin
			mode_status_d[LSB_PIN_A_CODE +: 3] = pin_sync_q[2:0];
			mode_status_d[BIT_PIN_A_DONE] = 1'b1;
		end
		if (pin_sync_q[7] && !mode_status_q[BIT_PIN_B_DONE]) begin
			mode_status_d[LSB_PIN_B_CODE +: 3] = pin_sync_q[6:4];
			mode_status_d[BIT_PIN_B_DONE] = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			mode_status_q <= RST_MODE_STATUS;
		end else begin
			mode_status_q <= mode_status_d;
		end
	end

	// ***************************************************************
	// Link error monitor
	// ***************************************************************
	err_mon_if em ();

	assign em.count_en = link_err_q[BIT_ERR_COUNT_EN];
	assign em.threshold = link_err_q[LSB_ERR_THRESHOLD +: 4];
	assign em.link_err = link_err;
	assign em.relock = link_relock;

	link_error_monitor u_err_mon (
		.clk (clk),
		.rst (rst),
		.mon (em)
	);

	// ***************************************************************
	// Derived control outputs
	// ***************************************************************
	logic [1:0] eq_restart_d;
	logic [3:0] eq_start_level_d;
	logic       eq_manual_en_d;
	logic [5:0] eq_manual_setting_d;
	logic [5:0] mclk_out_div_d;
	logic [3:0] ref_in_div_d;
	logic       spi_miso_o_d, spi_miso_oe_d, spi_drive_rise_d;
	logic       ctrl_high_speed_d, ctrl_spi_fwd_d, ctrl_spi_rev_d;
	logic [2:0] ctrl_gpio_lanes_d;
	logic [5:0] eq_level_view;
	ctrl_mode_t cmode;

	assign cmode = ctrl_mode_t'(back_ch_q[LSB_CTRL_MODE +: 3]);

	// Outputs are computed here and registered below so each leaves a flop
	always_comb begin
		eq_restart_d = {2{eq_ctrl_one_q[BIT_EQ_RESTART]}};
		eq_start_level_d = EQ_START_ZERO;
		if (eq_ctrl_one_q[BIT_FLOOR_OVR_EN] && eq_ctrl_one_q[BIT_FLOOR_APPLY]) begin
			eq_start_level_d = eq_floor_q[LSB_FLOOR_LEVEL +: 4];
		end
		eq_manual_en_d = eq_bypass_q[BIT_ADAPT_DISABLE];
		eq_manual_setting_d = {eq_bypass_q[LSB_FIRST_STAGE +: 3],
			eq_bypass_q[LSB_SECOND_STAGE +: 3]};
		mclk_out_div_d = audio_div_q[BIT_OUT_DIV_OVR] ?
			out_div_ratio(audio_div_q[LSB_OUT_DIV_CODE +: 3]) :
			out_div_ratio(auto_out_div_code);
		ref_in_div_d = audio_div_q[BIT_IN_DIV_OVR] ?
			in_div_ratio(audio_div_q[LSB_IN_DIV_CODE +: 2]) :
			in_div_ratio(auto_in_div_code);
		spi_drive_rise_d = back_ch_q[BIT_CLK_POLARITY];
		ctrl_high_speed_d = 1'b0;
		ctrl_gpio_lanes_d = 3'h0;
		ctrl_spi_fwd_d = 1'b0;
		ctrl_spi_rev_d = 1'b0;
		unique case (cmode)
			CM_GPIO: ctrl_gpio_lanes_d = 3'h0;
			CM_HS_GPIO_1: begin
				ctrl_high_speed_d = 1'b1;
				ctrl_gpio_lanes_d = 3'h1;
			end
			CM_HS_GPIO_2: begin
				ctrl_high_speed_d = 1'b1;
				ctrl_gpio_lanes_d = 3'h2;
			end
			CM_HS_GPIO_4: begin
				ctrl_high_speed_d = 1'b1;
				ctrl_gpio_lanes_d = 3'h4;
			end
			CM_SPI_FWD: ctrl_spi_fwd_d = 1'b1;
			CM_SPI_REV: ctrl_spi_rev_d = 1'b1;
			CM_HS_SPI_FWD: begin
				ctrl_high_speed_d = 1'b1;
				ctrl_spi_fwd_d = 1'b1;
			end
			CM_HS_SPI_REV: begin
				ctrl_high_speed_d = 1'b1;
				ctrl_spi_rev_d = 1'b1;
			end
		endcase
		// Bused slaves release the line while deselected if pin mode is set
		spi_miso_oe_d = ctrl_spi_rev_d &&
			(!back_ch_q[BIT_MISO_PIN_MODE] || !pin_sync_q[8]);
		spi_miso_o_d = spi_miso_data;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			eq_restart <= 2'h0;
			eq_start_level <= EQ_START_ZERO;
			eq_manual_en <= 1'b0;
			eq_manual_setting <= 6'h18;
			mclk_out_div <= 6'h20;
			ref_in_div <= 4'h1;
			spi_miso_o <= 1'b0;
			spi_miso_oe <= 1'b0;
			spi_drive_rise <= 1'b0;
			ctrl_high_speed <= 1'b0;
			ctrl_gpio_lanes <= 3'h0;
			ctrl_spi_fwd <= 1'b0;
			ctrl_spi_rev <= 1'b0;
		end else begin
			eq_restart <= eq_restart_d;
			eq_start_level <= eq_start_level_d;
			eq_manual_en <= eq_manual_en_d;
			eq_manual_setting <= eq_manual_setting_d;
			mclk_out_div <= mclk_out_div_d;
			ref_in_div <= ref_in_div_d;
			spi_miso_o <= spi_miso_o_d;
			spi_miso_oe <= spi_miso_oe_d;
			spi_drive_rise <= spi_drive_rise_d;
			ctrl_high_speed <= ctrl_high_speed_d;
			ctrl_gpio_lanes <= ctrl_gpio_lanes_d;
			ctrl_spi_fwd <= ctrl_spi_fwd_d;
			ctrl_spi_rev <= ctrl_spi_rev_d;
		end
	end

	assign link_lock = em.lock;

	// ***************************************************************
	// Read path
	// ***************************************************************
	// Status shows the manual setting while bypassed, else the live level
	assign eq_level_view = eq_bypass_q[BIT_ADAPT_DISABLE] ? eq_manual_setting_d : adapt_eq_level;

	always_comb begin
		rdata_d = rdata_q;
		if (reg_rd) begin
			unique case (reg_addr)
				ADDR_EQ_CTRL_ONE:  rdata_d = eq_ctrl_one_q;
				ADDR_MODE_STATUS:  rdata_d = mode_status_q;
				ADDR_AUDIO_DIV:    rdata_d = audio_div_q;
				ADDR_EQ_LEVEL:     rdata_d = {2'b00, eq_level_view};
				ADDR_LINK_ERR:     rdata_d = link_err_q;
				ADDR_BACK_CHANNEL: rdata_d = back_ch_q;
				ADDR_EQ_BYPASS:    rdata_d = eq_bypass_q;
				ADDR_EQ_FLOOR:     rdata_d = eq_floor_q;
				default:           rdata_d = RD_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q <= RD_UNMAPPED;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
endmodule

// ==== include/link_eq_pkg.sv ====
package link_eq_pkg;

	// ***************************************************************
	// Register offsets
	// ***************************************************************
	localparam logic [7:0] ADDR_EQ_CTRL_ONE  = 8'h35;
	localparam logic [7:0] ADDR_MODE_STATUS  = 8'h37;
	localparam logic [7:0] ADDR_AUDIO_DIV    = 8'h3a;
	localparam logic [7:0] ADDR_EQ_LEVEL     = 8'h3b;
	localparam logic [7:0] ADDR_LINK_ERR     = 8'h41;
	localparam logic [7:0] ADDR_BACK_CHANNEL = 8'h43;
	localparam logic [7:0] ADDR_EQ_BYPASS    = 8'h44;
	localparam logic [7:0] ADDR_EQ_FLOOR     = 8'h45;

	// ***************************************************************
	// Reset values and writable masks
	// ***************************************************************
	localparam logic [7:0] RST_EQ_CTRL_ONE   = 8'h00;
	localparam logic [7:0] RST_MODE_STATUS   = 8'h00;
	localparam logic [7:0] RST_AUDIO_DIV     = 8'h00;
	localparam logic [7:0] RST_LINK_ERR      = 8'h03;
	localparam logic [7:0] RST_BACK_CHANNEL  = 8'h00;
	localparam logic [7:0] RST_EQ_BYPASS     = 8'h60;
	localparam logic [7:0] RST_EQ_FLOOR      = 8'h08;
	localparam logic [7:0] RD_UNMAPPED       = 8'h00;
	localparam logic [7:0] WMASK_EQ_CTRL_ONE = 8'h70;
	localparam logic [7:0] WMASK_AUDIO_DIV   = 8'hf7;
	localparam logic [7:0] WMASK_LINK_ERR    = 8'h1f;
	localparam logic [7:0] WMASK_BACK_CH     = 8'h1f;
	localparam logic [7:0] WMASK_EQ_BYPASS   = 8'hef;
	localparam logic [7:0] WMASK_EQ_FLOOR    = 8'h0f;

	// ***************************************************************
	// Field positions
	// ***************************************************************
	localparam int BIT_EQ_RESTART    = 6;
	localparam int BIT_FLOOR_OVR_EN  = 5;
	localparam int BIT_FLOOR_APPLY   = 4;
	localparam int BIT_PIN_B_DONE    = 7;
	localparam int LSB_PIN_B_CODE    = 4;
	localparam int BIT_PIN_A_DONE    = 3;
	localparam int LSB_PIN_A_CODE    = 0;
	localparam int BIT_OUT_DIV_OVR   = 7;
	localparam int LSB_OUT_DIV_CODE  = 4;
	localparam int BIT_IN_DIV_OVR    = 2;
	localparam int LSB_IN_DIV_CODE   = 0;
	localparam int BIT_ERR_COUNT_EN  = 4;
	localparam int LSB_ERR_THRESHOLD = 0;
	localparam int BIT_MISO_PIN_MODE = 4;
	localparam int BIT_CLK_POLARITY  = 3;
	localparam int LSB_CTRL_MODE     = 0;
	localparam int LSB_FIRST_STAGE   = 5;
	localparam int LSB_SECOND_STAGE  = 1;
	localparam int BIT_ADAPT_DISABLE = 0;
	localparam int LSB_FLOOR_LEVEL   = 0;

	localparam logic [3:0] EQ_START_ZERO = 4'h0;
	localparam logic [3:0] ERR_COUNT_MAX = 4'hf;

	// ***************************************************************
	// Control channel modes
	// ***************************************************************
	typedef enum logic [2:0] {
		CM_GPIO        = 3'b000,
		CM_HS_GPIO_1   = 3'b001,
		CM_HS_GPIO_2   = 3'b010,
		CM_HS_GPIO_4   = 3'b011,
		CM_SPI_FWD     = 3'b100,
		CM_SPI_REV     = 3'b101,
		CM_HS_SPI_FWD  = 3'b110,
		CM_HS_SPI_REV  = 3'b111
	} ctrl_mode_t;

	// Oscillator output divide ratio, 1 to 32
	function automatic logic [5:0] out_div_ratio(input logic [2:0] code);
		logic [5:0] r;
		r = 6'h01;
		case (code)
			3'h0: r = 6'h20;
			3'h1: r = 6'h10;
			3'h2: r = 6'h08;
			3'h3: r = 6'h04;
			3'h4, 3'h5: r = 6'h02;
			default: r = 6'h01;
		endcase
		return r;
	endfunction

	// Reference input divide ratio, 1 to 8
	function automatic logic [3:0] in_div_ratio(input logic [1:0] code);
		logic [3:0] r;
		r = 4'h1;
		case (code)
			2'h0: r = 4'h1;
			2'h1: r = 4'h2;
			2'h2: r = 4'h4;
			default: r = 4'h8;
		endcase
		return r;
	endfunction

endpackage

// ==== include/err_mon_if.sv ====
`timescale 1ns/1ps
interface err_mon_if;
	logic       count_en;
	logic [3:0] threshold;
	logic [2:0] link_err;
	logic       relock;
	logic       lock;
	logic [3:0] err_count;

	modport cfg (output count_en, output threshold, output link_err, output relock, input lock, input err_count);
	modport mon (input count_en, input threshold, input link_err, input relock, output lock, output err_count);
endinterface

// ==== verilog/link_error_monitor.sv ====
`timescale 1ns/1ps
module link_error_monitor (
	input wire logic clk,
	input wire logic rst,
	err_mon_if.mon   mon
);
	import link_eq_pkg::*;

	logic       lock_q;
	logic       lock_d;
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic [4:0] sum;

	// ***************************************************************
	// Error counting and lock decision
	// ***************************************************************
	// Errors of all three monitored channels in one cycle add together
	always_comb begin
		sum = 5'({1'b0, cnt_q}) + 5'(mon.link_err[0]) + 5'(mon.link_err[1]) + 5'(mon.link_err[2]);
		cnt_d = cnt_q;
		lock_d = lock_q;
		if (mon.relock) begin
			cnt_d = EQ_START_ZERO;
			lock_d = 1'b1;
		end else if (lock_q && (|mon.link_err)) begin
			if (!mon.count_en) begin
				lock_d = 1'b0;
			end else begin
				cnt_d = (sum > 5'(ERR_COUNT_MAX)) ? ERR_COUNT_MAX : sum[3:0];
				if (sum >= 5'(mon.threshold)) begin
					lock_d = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			lock_q <= 1'b0;
			cnt_q <= EQ_START_ZERO;
		end else begin
			lock_q <= lock_d;
			cnt_q <= cnt_d;
		end
	end

	assign mon.lock = lock_q;
	assign mon.err_count = cnt_q;
endmodule

// ==== tb/link_eq_regs_props.sv ====
`timescale 1ns/1ps
module link_eq_regs_checker (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [2:0] link_err,
	input wire logic       link_relock,
	input wire logic [1:0] eq_restart,
	input wire logic       eq_manual_en,
	input wire logic [5:0] eq_manual_setting,
	input wire logic       link_lock,
	input wire logic       spi_miso_oe,
	input wire logic       ctrl_spi_fwd,
	input wire logic       ctrl_spi_rev
);
	import link_eq_pkg::*;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// ***************************************************************
	// Register writes reaching the derived outputs
	// ***************************************************************
	// One write followed by a quiet cycle, so the output two edges on has a single cause
	sequence wr_alone(a);
		reg_wr && reg_addr == a ##1 !(reg_wr && reg_addr == a);
	endsequence

	restart_both_ports_a: assert property (wr_alone(ADDR_EQ_CTRL_ONE) |=>
		eq_restart == {2{$past(reg_wdata[6], 2)}}) else $error("restart not mirrored to both ports");
	manual_eq_setting_a: assert property (wr_alone(ADDR_EQ_BYPASS) |=>
		eq_manual_en == $past(reg_wdata[0], 2) &&
		eq_manual_setting == {$past(reg_wdata[7:5], 2), $past(reg_wdata[3:1], 2)})
		else $error("manual equalizer setting wrong");
	spi_mode_decode_a: assert property (wr_alone(ADDR_BACK_CHANNEL) |=>
		ctrl_spi_rev == ($past(reg_wdata[2:0], 2) inside {3'b101, 3'b111}) &&
		ctrl_spi_fwd == ($past(reg_wdata[2:0], 2) inside {3'b100, 3'b110}))
		else $error("spi mode decode wrong");
	miso_only_reverse_a: assert property (spi_miso_oe |-> ctrl_spi_rev)
		else $error("miso driven outside reverse mode");

	// ***************************************************************
	// Lock and status
	// ***************************************************************
	relock_gives_lock_a: assert property (link_relock |=> link_lock)
		else $error("relock did not give lock");
	lock_rise_cause_a: assert property ($rose(link_lock) |-> $past(link_relock))
		else $error("lock rose without relock");
	lock_fall_cause_a: assert property ($fell(link_lock) |-> $past(link_err) != 3'h0)
		else $error("lock fell without a link error");
	floor_reserved_a: assert property (reg_rd && reg_addr == ADDR_EQ_FLOOR |=> reg_rdata[7:4] == 4'h0)
		else $error("floor reserved bits not zero");
	code_needs_done_a: assert property (reg_rd && reg_addr == ADDR_MODE_STATUS |=>
		(reg_rdata[7] || reg_rdata[6:4] == 3'h0) && (reg_rdata[3] || reg_rdata[2:0] == 3'h0))
		else $error("mode code shown before done");
endmodule

bind link_eq_regs link_eq_regs_checker chk_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_err(link_err), .link_relock(link_relock),
	.eq_restart(eq_restart), .eq_manual_en(eq_manual_en), .eq_manual_setting(eq_manual_setting),
	.link_lock(link_lock), .spi_miso_oe(spi_miso_oe), .ctrl_spi_fwd(ctrl_spi_fwd), .ctrl_spi_rev(ctrl_spi_rev));

// ==== tb/tb_link_eq_regs.sv ====
`timescale 1ns/1ps
module tb_link_eq_regs;
	import link_eq_pkg::*;

	logic       clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic [2:0] mode_a_level = 3'h0, mode_b_level = 3'h0, auto_out_div_code = 3'h0, link_err = 3'h0;
	logic       mode_a_valid = 1'b0, mode_b_valid = 1'b0, link_relock = 1'b0;
	logic       spi_ss_n = 1'b1, spi_miso_data = 1'b0;
	logic [1:0] auto_in_div_code = 2'h0, eq_restart;
	logic [5:0] adapt_eq_level = 6'h2a, eq_manual_setting, mclk_out_div;
	logic [3:0] eq_start_level, ref_in_div;
	logic       eq_manual_en, link_lock, spi_miso_o, spi_miso_oe, spi_drive_rise;
	logic       ctrl_high_speed, ctrl_spi_fwd, ctrl_spi_rev;
	logic [2:0] ctrl_gpio_lanes;
	int         failures = 0, checks = 0;

	always #5 clk = ~clk;

	link_eq_regs dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode_a_level(mode_a_level), .mode_a_valid(mode_a_valid),
		.mode_b_level(mode_b_level), .mode_b_valid(mode_b_valid), .auto_out_div_code(auto_out_div_code),
		.auto_in_div_code(auto_in_div_code), .adapt_eq_level(adapt_eq_level), .link_err(link_err),
		.link_relock(link_relock), .spi_ss_n(spi_ss_n), .spi_miso_data(spi_miso_data), .eq_restart(eq_restart),
		.eq_start_level(eq_start_level), .eq_manual_en(eq_manual_en), .eq_manual_setting(eq_manual_setting),
		.mclk_out_div(mclk_out_div), .ref_in_div(ref_in_div), .link_lock(link_lock), .spi_miso_o(spi_miso_o),
		.spi_miso_oe(spi_miso_oe), .spi_drive_rise(spi_drive_rise), .ctrl_high_speed(ctrl_high_speed),
		.ctrl_gpio_lanes(ctrl_gpio_lanes), .ctrl_spi_fwd(ctrl_spi_fwd), .ctrl_spi_rev(ctrl_spi_rev));

	// ***************************************************************
	// Shared bus and compare tasks
	// ***************************************************************
	task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Strobes move only at falling edges, so the sampling edge never races them
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 1'b0;
		@(negedge clk);
		cmp8("reg_rdata", exp, reg_rdata);
	endtask

	// Derived outputs trail the register by one more edge
	task automatic settle;
		repeat (3) @(negedge clk);
	endtask

	task automatic pulse(input logic [2:0] e, input logic r);
		@(negedge clk);
		link_err = e;
		link_relock = r;
		@(negedge clk);
		link_err = 3'h0;
		link_relock = 1'b0;
		repeat (2) @(negedge clk);
	endtask

	// ***************************************************************
	// Scenarios
	// ***************************************************************
	task automatic t_reset;
		logic [7:0] a [7] = '{8'h35, 8'h37, 8'h3a, 8'h41, 8'h43, 8'h44, 8'h45};
		logic [7:0] v [7] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h60, 8'h08};
		for (int i = 0; i < 7; i++) begin
			rd(a[i], v[i]);
		end
		rd(8'h00, 8'h00);
		rd(8'h3b, 8'h2a);
		cmp8("link_lock", 8'h00, {7'b0, link_lock});
		cmp8("eq_manual_en", 8'h00, {7'b0, eq_manual_en});
		cmp8("eq_restart", 8'h00, {6'b0, eq_restart});
		cmp8("eq_start_level", 8'h00, {4'b0, eq_start_level});
		cmp8("eq_manual_setting", 8'h18, {2'b0, eq_manual_setting});
		cmp8("mclk_out_div", 8'h20, {2'b0, mclk_out_div});
		cmp8("ref_in_div", 8'h01, {4'b0, ref_in_div});
	endtask

	task automatic t_restart;
		wr(8'h35, 8'hff);
		settle;
		rd(8'h35, 8'h70);
		cmp8("eq_restart", 8'h03, {6'b0, eq_restart});
		cmp8("eq_start_level", 8'h08, {4'b0, eq_start_level});
		wr(8'h35, 8'h00);
		settle;
		cmp8("eq_restart", 8'h00, {6'b0, eq_restart});
	endtask

	task automatic t_floor;
		wr(8'h45, 8'hf5);
		wr(8'h35, 8'h10);
		settle;
		rd(8'h45, 8'h05);
		cmp8("eq_start_level", 8'h00, {4'b0, eq_start_level});
		wr(8'h35, 8'h30);
		settle;
		cmp8("eq_start_level", 8'h05, {4'b0, eq_start_level});
		wr(8'h35, 8'h20);
		settle;
		cmp8("eq_start_level", 8'h00, {4'b0, eq_start_level});
	endtask

	// Latched codes must ignore later pin changes and register writes
	task automatic t_mode;
		mode_a_level = 3'h5;
		mode_a_valid = 1'b1;
		repeat (6) @(negedge clk);
		rd(8'h37, 8'h0d);
		mode_b_level = 3'h3;
		mode_b_valid = 1'b1;
		repeat (6) @(negedge clk);
		mode_a_level = 3'h2;
		mode_b_level = 3'h6;
		wr(8'h37, 8'h00);
		repeat (6) @(negedge clk);
		rd(8'h37, 8'hbd);
	endtask

	task automatic t_div;
		logic [5:0] o [8] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h02, 6'h01, 6'h01};
		for (int c = 0; c < 8; c++) begin
			wr(8'h3a, {1'b1, c[2:0], 2'b01, c[1:0]});
			settle;
			cmp8("mclk_out_div", {2'b0, o[c]}, {2'b0, mclk_out_div});
			cmp8("ref_in_div", 8'h01 << c[1:0], {4'b0, ref_in_div});
		end
		auto_out_div_code = 3'h3;
		auto_in_div_code = 2'h2;
		wr(8'h3a, 8'h08);
		settle;
		rd(8'h3a, 8'h00);
		cmp8("mclk_out_div", 8'h04, {2'b0, mclk_out_div});
		cmp8("ref_in_div", 8'h04, {4'b0, ref_in_div});
	endtask

	task automatic t_lock;
		pulse(3'h0, 1'b1);
		cmp8("link_lock", 8'h01, {7'b0, link_lock});
		pulse(3'h4, 1'b0);
		cmp8("link_lock", 8'h00, {7'b0, link_lock});
		wr(8'h41, 8'hf3);
		rd(8'h41, 8'h13);
		pulse(3'h0, 1'b1);
		pulse(3'h1, 1'b0);
		pulse(3'h2, 1'b0);
		cmp8("link_lock", 8'h01, {7'b0, link_lock});
		pulse(3'h4, 1'b0);
		cmp8("link_lock", 8'h00, {7'b0, link_lock});
		pulse(3'h0, 1'b1);
		pulse(3'h7, 1'b0);
		cmp8("link_lock", 8'h00, {7'b0, link_lock});
	endtask

	// Packed as high speed, lanes, forward, reverse, drive edge, miso enable
	task automatic t_back;
		logic [7:0] x [8] = '{8'h00, 8'h92, 8'ha0, 8'hc2, 8'h08, 8'h07, 8'h88, 8'h87};
		for (int m = 0; m < 8; m++) begin
			wr(8'h43, {4'b0, m[0], m[2:0]});
			settle;
			cmp8("ctrl", x[m], {ctrl_high_speed, ctrl_gpio_lanes, ctrl_spi_fwd, ctrl_spi_rev,
				spi_drive_rise, spi_miso_oe});
		end
		wr(8'h43, 8'h15);
		settle;
		cmp8("spi_miso_oe", 8'h00, {7'b0, spi_miso_oe});
		spi_ss_n = 1'b0;
		spi_miso_data = 1'b1;
		repeat (5) @(negedge clk);
		cmp8("spi_miso", 8'h03, {6'b0, spi_miso_oe, spi_miso_o});
		spi_ss_n = 1'b1;
	endtask

	task automatic t_bypass;
		wr(8'h44, 8'hff);
		settle;
		rd(8'h44, 8'hef);
		rd(8'h3b, 8'h3f);
		wr(8'h44, 8'ha5);
		wr(8'h3b, 8'h00);
		settle;
		cmp8("eq_manual", 8'h6a, {1'b0, eq_manual_en, eq_manual_setting});
	endtask

	task automatic tally_and_finish;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ***************************************************************
	// Main sequence and hang guard
	// ***************************************************************
	initial begin
		repeat (6) @(negedge clk);
		rst = 1'b0;
		t_reset;
		t_restart;
		t_floor;
		t_mode;
		t_div;
		t_lock;
		t_back;
		t_bypass;
		tally_and_finish;
	end

	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		tally_and_finish;
	end
endmodule
